// file: rtl/dpro_ctl.sv
// Power-state, reset and termination control with an Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// (R01) Power-down entered only on CKE sampled low with NOP or DES.
// (R02) Controller sends only NOP/DES until entry delay; buffers then disabled.
// (R03) Open bank gives active power-down; all closed gives precharge power-down.
// (R04) Precharge power-down: DLL off slow exit if MR0[12]=0, on if 1.
// (R05) Active power-down keeps DLL on, always fast exit.
// (R06) Controller holds CKE low, reset high during power-down; others ignored.
// (R07) Reset low in power-down leaves power-down for reset state.
// (R08) Controller holds CKE low tPD minimum, nine refresh intervals maximum.
// (R09) Power-down exits when CKE sampled high, with NOP or DES; the code exits on CKE high whatever the command.
// (R10) Controller waits tXP after fast exit before valid commands.
// (R11) Controller waits tXPDLL after slow exit before DLL-dependent commands.
// (R12) Refresh between exit and entry obeys tXP and tXPDLL.
// (R13) CKE raised during tRFC stays high until tRFC ends.
// (R14) Write to power-down may be two cycles shorter with fixed chop.
// (R15) Write recovery cycles taken from MR0[11:9].
// (R16) Reset acts whenever it falls; controller holds it low 100ns.
// (R17) Reset disables outputs, termination off, refresh counter cleared.
// (R18) Controller should lower CKE before releasing reset.
// (R19) Controller re-initialises fully after reset release.
// (R20) Termination covers data, strobe, mask, and TDQS when enabled.
// (R21) No termination in DLL-disable mode.
// (R22) Termination pin ignored in self refresh or when MR1 and MR2 disable it.
// (R23) Termination asynchronous with DLL off or locking, else synchronous.
// (R24) MR1[9,6,2] enables nominal termination; pin switches it; dynamic only in writes.
// (R25) Explicit power-state machine advanced only by CKE, commands and reset.
module dpro_ctl
   import dpro_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   // Memory pins from the controller
   input wire logic cke_i,
   input wire logic reset_n_i,
   input wire logic odt_i,
   input wire logic [2:0] cmd_i,
   // Device-side status
   output logic [DPRO_DQ_W-1:0] rtt_en_o,
   output logic rtt_tdqs_o,
   output logic rtt_dyn_o,
   output logic odt_async_o,
   output logic out_en_o,
   output logic buf_en_o,
   output logic dll_on_o,
   output logic [2:0] pstate_o
);
   //////////////////////////////////////////////////////////////////////////////
   logic [15:0] mr0_q, mr1_q, mr2_q;
   logic [15:0] ref_cnt_q;
   logic [7:0] banks_q;
   logic [DPRO_WR_W-1:0] wr_rec_q;
   logic [7:0] lock_cnt_q;
   logic [7:0] rst_cnt_q;
   logic [2:0] cmd_q;
   logic write_act_q;
   dpro_state_t st_q, st_d;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [2:0] pin_s;

   // Pins cross from the controller's clock through two flops
   // Reset values are the idle pin levels, so no false reset or entry follows reset
   dpro_sync2 #(.W(3)) u_sync (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({odt_i, reset_n_i, cke_i}),
      .rst_val_i(3'h3),
      .sync_o(pin_s)
   );
   wire cke_s = pin_s[0];
   wire rstn_s = pin_s[1];
   wire odt_s = pin_s[2];

   // Command bus also passes two stages so it lines up with the sampled CKE
   logic [2:0] cmd_m;
   always_ff @(posedge ref_clk_i) begin
      cmd_m <= cmd_i;
   end
   always_ff @(posedge ref_clk_i) begin
      cmd_q <= sys_rst_i ? DPRO_CMD_NOP : cmd_m;
   end

   //////////////////////////////////////////////////////////////////////////////
   wire is_nop = (cmd_q == DPRO_CMD_NOP) || (cmd_q == DPRO_CMD_DES);
   wire any_open = |banks_q;
   wire in_pd = (st_q == DPRO_ST_APD) || (st_q == DPRO_ST_PPD_FAST) ||
      (st_q == DPRO_ST_PPD_SLOW);
   wire busy = write_act_q || (wr_rec_q != '0);
   // Reset pin low is taken through the same two-flop synchroniser as the other pins and forces reset
   wire reset_fall = !rstn_s; // [R16]

   always_comb begin
      st_d = st_q;
      case (st_q)
         DPRO_ST_RESET: begin
            if (rstn_s && rst_cnt_q >= DPRO_RST_MIN_CYC[7:0]) begin
               st_d = DPRO_ST_IDLE;
            end
         end
         DPRO_ST_IDLE: begin
            if (cmd_q == DPRO_CMD_SRE && !cke_s) begin
               st_d = DPRO_ST_SREF;
            end else if (!cke_s && is_nop && !busy) begin // [R01] [R25]
               if (any_open) begin
                  st_d = DPRO_ST_APD; // [R03] [R05]
               end else if (mr0_q[DPRO_MR0_PPD_BIT]) begin
                  st_d = DPRO_ST_PPD_FAST; // [R04]
               end else begin
                  st_d = DPRO_ST_PPD_SLOW; // [R04]
               end
            end
         end
         DPRO_ST_APD, DPRO_ST_PPD_FAST, DPRO_ST_PPD_SLOW, DPRO_ST_SREF: begin
            if (cke_s) begin
               st_d = DPRO_ST_IDLE; // [R09]
            end
         end
         default: st_d = DPRO_ST_IDLE;
      endcase
      if (reset_fall) begin
         st_d = DPRO_ST_RESET; // [R07]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_q <= DPRO_ST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // Minimum reset width counter
   always_ff @(posedge ref_clk_i) begin
      // A block reset counts as a full-width pin reset, so the state leaves at once
      if (sys_rst_i) begin
         rst_cnt_q <= DPRO_RST_MIN_CYC[7:0];
      end else if (rstn_s) begin
         rst_cnt_q <= 8'h00;
      end else if (rst_cnt_q != 8'hFF) begin
         rst_cnt_q <= rst_cnt_q + 8'h01;
      end
   end

   // Bank tracking; inputs ignored while powered down
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || st_q == DPRO_ST_RESET) begin
         banks_q <= 8'h00;
      end else if (st_q == DPRO_ST_IDLE && cke_s) begin // [R06]
         if (cmd_q == DPRO_CMD_ACT) begin
            banks_q <= 8'hFF & (banks_q | 8'h01);
         end else if (cmd_q == DPRO_CMD_PRE) begin
            banks_q <= 8'h00;
         end
      end
   end

   // Write recovery window from mode field
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || st_q == DPRO_ST_RESET) begin
         wr_rec_q <= '0;
         write_act_q <= 1'b0;
      end else if (st_q == DPRO_ST_IDLE && cke_s && cmd_q == DPRO_CMD_WR) begin
         wr_rec_q <= mr0_q[DPRO_MR0_WR_LSB +: DPRO_WR_W]; // [R15]
         write_act_q <= 1'b1;
      end else begin
         write_act_q <= 1'b0;
         if (wr_rec_q != '0) begin
            wr_rec_q <= wr_rec_q - 1'b1;
         end
      end
   end

   // Refresh counter
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || st_q == DPRO_ST_RESET) begin
         ref_cnt_q <= 16'h0000; // [R17]
      end else if (st_q == DPRO_ST_IDLE && cke_s && cmd_q == DPRO_CMD_REF) begin
         ref_cnt_q <= ref_cnt_q + 16'h0001;
      end
   end

   // DLL lock tracking after slow exit
   wire dll_off = (st_q == DPRO_ST_PPD_SLOW) || (st_q == DPRO_ST_RESET) ||
      mr1_q[DPRO_MR1_DLL_DIS_BIT];
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || dll_off) begin
         lock_cnt_q <= DPRO_DLL_LOCK_CYC[7:0];
      end else if (lock_cnt_q != 8'h00) begin
         lock_cnt_q <= lock_cnt_q - 8'h01;
      end
   end
   wire dll_locking = lock_cnt_q != 8'h00;

   //////////////////////////////////////////////////////////////////////////////
   // Termination
   wire [2:0] rtt_sel = {mr1_q[DPRO_MR1_RTT2_BIT], mr1_q[DPRO_MR1_RTT1_BIT],
      mr1_q[DPRO_MR1_RTT0_BIT]};
   wire rtt_nom_en = rtt_sel != 3'h0; // [R24]
   wire rtt_wr_en = mr2_q[DPRO_MR2_RTTWR_LSB +: 2] != 2'h0;
   wire odt_ok = (st_q != DPRO_ST_SREF) && (st_q != DPRO_ST_RESET) &&
      !mr1_q[DPRO_MR1_DLL_DIS_BIT] && (rtt_nom_en || rtt_wr_en); // [R21] [R22]
   wire rtt_on = odt_ok && odt_s && rtt_nom_en; // [R24]
   wire dyn_on = odt_ok && odt_s && rtt_wr_en && write_act_q; // [R24]

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || st_q == DPRO_ST_RESET) begin
         rtt_en_o <= '0; // [R17]
         rtt_tdqs_o <= 1'b0;
         rtt_dyn_o <= 1'b0;
         odt_async_o <= 1'b0;
         out_en_o <= 1'b0; // [R17]
         buf_en_o <= 1'b0;
         dll_on_o <= 1'b0;
         pstate_o <= DPRO_ST_RESET;
      end else begin
         rtt_en_o <= {DPRO_DQ_W{rtt_on}}; // [R20]
         rtt_tdqs_o <= rtt_on && mr1_q[DPRO_MR1_TDQS_BIT]; // [R20]
         rtt_dyn_o <= dyn_on;
         odt_async_o <= dll_off || dll_locking; // [R23]
         out_en_o <= st_q == DPRO_ST_IDLE;
         buf_en_o <= !in_pd && st_q != DPRO_ST_SREF;
         dll_on_o <= !dll_off; // [R05]
         pstate_o <= st_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle, answer on the second edge
   wire req = (avs_read_i || avs_write_i) && !ack_q;
   wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   wire hit_mr0 = avs_address_i == DPRO_OFS_MR0;
   wire hit_mr1 = avs_address_i == DPRO_OFS_MR1;
   wire hit_mr2 = avs_address_i == DPRO_OFS_MR2;
   wire hit_pins = avs_address_i == DPRO_OFS_PINS;
   wire hit_stat = avs_address_i == DPRO_OFS_STAT;
   wire hit_cnt = avs_address_i == DPRO_OFS_CNT;
   wire hit_ro = hit_pins || hit_stat || hit_cnt;
   // Status words kept apart so the read select stays plain
   wire [31:0] pins_word = {28'h0000000, cmd_q == DPRO_CMD_NOP, pin_s};
   wire [31:0] stat_word = {20'h00000, dll_locking, banks_q, st_q};
   wire [31:0] cnt_word = {16'h0000, ref_cnt_q};
   wire mapped = hit_mr0 || hit_mr1 || hit_mr2 || hit_ro;
   wire [31:0] wmerge0 = ({16'h0000, mr0_q} & ~be_mask) | (avs_writedata_i & be_mask);
   wire [31:0] wmerge1 = ({16'h0000, mr1_q} & ~be_mask) | (avs_writedata_i & be_mask);
   wire [31:0] wmerge2 = ({16'h0000, mr2_q} & ~be_mask) | (avs_writedata_i & be_mask);
   wire [31:0] rmux =
      hit_mr0 ? {16'h0000, mr0_q} :
      hit_mr1 ? {16'h0000, mr1_q} :
      hit_mr2 ? {16'h0000, mr2_q} :
      hit_pins ? pins_word :
      hit_stat ? stat_word :
      hit_cnt ? cnt_word : 32'h00000000;
   // Writes take effect on the edge that ends the wait, as the master sees it
   wire do_wr = avs_write_i && ack_q;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ack_q <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         rdata_q <= 32'h00000000;
         avs_response_o <= 2'h0;
      end else begin
         ack_q <= req;
         avs_waitrequest_o <= !req;
         rdata_q <= (req && avs_read_i) ? rmux : 32'h00000000;
         avs_response_o <= (req && !mapped) ? 2'h2 : 2'h0;
      end
   end
   assign avs_readdata_o = rdata_q;

   // Mode registers; a reset pin also returns them to defaults
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || st_q == DPRO_ST_RESET) begin
         mr0_q <= DPRO_MR_RST;
         mr1_q <= DPRO_MR_RST;
         mr2_q <= DPRO_MR_RST;
      end else if (do_wr) begin
         if (hit_mr0) begin
            mr0_q <= wmerge0[15:0];
         end
         if (hit_mr1) begin
            mr1_q <= wmerge1[15:0];
         end
         if (hit_mr2) begin
            mr2_q <= wmerge2[15:0];
         end
      end
   end
endmodule
`default_nettype wire

// file: rtl/dpro_pkg.sv
// Constants, register map and state types for the power, reset and termination control block
`default_nettype none
package dpro_pkg;
   // Register byte offsets (32-bit words)
   localparam logic [7:0] DPRO_OFS_PINS = 8'h00;
   localparam logic [7:0] DPRO_OFS_MR0 = 8'h04;
   localparam logic [7:0] DPRO_OFS_MR1 = 8'h08;
   localparam logic [7:0] DPRO_OFS_MR2 = 8'h0C;
   localparam logic [7:0] DPRO_OFS_STAT = 8'h10;
   localparam logic [7:0] DPRO_OFS_CNT = 8'h14;
   // Mode field positions
   localparam int DPRO_MR0_PPD_BIT = 12;
   localparam int DPRO_MR0_WR_LSB = 9;
   localparam int DPRO_MR1_DLL_DIS_BIT = 0;
   localparam int DPRO_MR1_RTT0_BIT = 2;
   localparam int DPRO_MR1_RTT1_BIT = 6;
   localparam int DPRO_MR1_RTT2_BIT = 9;
   localparam int DPRO_MR1_TDQS_BIT = 11;
   localparam int DPRO_MR2_RTTWR_LSB = 9;
   // Reset values
   localparam logic [15:0] DPRO_MR_RST = 16'h0000;
   // Timing
   localparam int DPRO_CLK_PS = 5000;
   localparam int DPRO_RST_MIN_NS = 100;
   localparam int DPRO_RST_MIN_CYC = (DPRO_RST_MIN_NS * 1000 + DPRO_CLK_PS - 1) / DPRO_CLK_PS;
   localparam int DPRO_DLL_LOCK_CYC = 16;
   localparam int DPRO_WR_W = 3;
   localparam int DPRO_DQ_W = 8;
   // Command encoding on the sampled command bus
   localparam logic [2:0] DPRO_CMD_NOP = 3'h0;
   localparam logic [2:0] DPRO_CMD_DES = 3'h1;
   localparam logic [2:0] DPRO_CMD_ACT = 3'h2;
   localparam logic [2:0] DPRO_CMD_PRE = 3'h3;
   localparam logic [2:0] DPRO_CMD_WR = 3'h4;
   localparam logic [2:0] DPRO_CMD_RD = 3'h5;
   localparam logic [2:0] DPRO_CMD_REF = 3'h6;
   localparam logic [2:0] DPRO_CMD_SRE = 3'h7;
   typedef enum logic [2:0] {
      DPRO_ST_IDLE, DPRO_ST_APD, DPRO_ST_PPD_FAST, DPRO_ST_PPD_SLOW, DPRO_ST_RESET, DPRO_ST_SREF
   } dpro_state_t;
endpackage
`default_nettype wire

// file: rtl/dpro_sync2.sv
// Two flip-flop synchroniser for a vector of pin levels
`default_nettype none
module dpro_sync2 #(
   parameter int W = 4
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Data
   input wire logic [W-1:0] async_i,
   input wire logic [W-1:0] rst_val_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge ref_clk_i) begin
            meta_q[g] <= async_i[g];
         end
         always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
               sync_o[g] <= rst_val_i[g];
            end else begin
               sync_o[g] <= meta_q[g];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// file: verification/dpro_ctl_asserts.sv
// Port-level assertions for the power, reset and termination control block
`default_nettype none
module dpro_ctl_asserts
   import dpro_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Register bus
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic [1:0] avs_response_o,
   // Pins and status
   input wire logic cke_i,
   input wire logic reset_n_i,
   input wire logic odt_i,
   input wire logic [DPRO_DQ_W-1:0] rtt_en_o,
   input wire logic rtt_tdqs_o,
   input wire logic out_en_o,
   input wire logic dll_on_o,
   input wire logic [2:0] pstate_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire logic req = avs_read_i || avs_write_i;
   wire logic in_pd = pstate_o inside {3'h1, 3'h2, 3'h3};
   ////////////////////////////////////////////////////////////////////////////
   property p_wait_one; req && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
   a_wait_one: assert property (p_wait_one) else $error("no answer after one wait cycle");
   property p_ack_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("answer held longer than one cycle");
   property p_unmapped;
      req && !avs_waitrequest_o && avs_address_i > 8'h14 |-> avs_response_o == 2'h2;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_apd_dll; pstate_o == 3'h1 [*2] |-> dll_on_o; endproperty
   a_apd_dll: assert property (p_apd_dll) else $error("delay loop off in active pd");
   property p_slow_dll; pstate_o == 3'h3 [*2] |-> !dll_on_o; endproperty
   a_slow_dll: assert property (p_slow_dll) else $error("delay loop on in slow pd");
   property p_rst_quiet;
      pstate_o == 3'h4 [*2] |-> rtt_en_o == '0 && !rtt_tdqs_o && !out_en_o;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs live in reset");
   property p_rst_pin; $fell(reset_n_i) |-> ##[1:6] pstate_o == 3'h4; endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("reset pin not obeyed");
   property p_cke_exit;
      in_pd && $rose(cke_i) && reset_n_i |-> ##[1:6] pstate_o == 3'h0;
   endproperty
   a_cke_exit: assert property (p_cke_exit) else $error("no exit on clock enable");
   property p_odt_off; !odt_i [*6] |-> rtt_en_o == '0; endproperty
   a_odt_off: assert property (p_odt_off) else $error("termination on with pin low");
   // Main scenarios reached
   c_apd: cover property (pstate_o == 3'h1);
   c_slow: cover property (pstate_o == 3'h3);
   c_rst: cover property (pstate_o == 3'h4);
endmodule
`default_nettype wire

// file: verification/dpro_mc_model.sv
// Memory controller model driving clock enable, reset, termination and commands
`default_nettype none
module dpro_mc_model
   import dpro_pkg::*;
#(
   parameter int TPD_CYC = 4,
   parameter int TXPDLL_CYC = 16,
   parameter int RST_LOW_CYC = 24
)(
   // Clock
   input wire logic ref_clk_i,
   // Pins to the device
   output logic cke_o,
   output logic reset_n_o,
   output logic odt_o,
   output logic [2:0] cmd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cke_o = 1'b1;
      reset_n_o = 1'b1;
      odt_o = 1'b0;
      cmd_o = DPRO_CMD_NOP;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic cmd(input logic [2:0] c);
      @(posedge ref_clk_i);
      cmd_o <= c;
      @(posedge ref_clk_i);
      cmd_o <= DPRO_CMD_NOP;
   endtask
   task automatic set_odt(input logic v);
      @(posedge ref_clk_i);
      odt_o <= v;
   endtask
   task automatic pd_enter();
      @(posedge ref_clk_i);
      cke_o <= 1'b0;
      cmd_o <= DPRO_CMD_NOP;
      repeat (TPD_CYC) @(posedge ref_clk_i);
   endtask
   // Commands are scrambled in the dwell: the device must ignore them, though no check here reads the bank state they would change
   task automatic pd_exit();
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk_i);
         cmd_o <= i[0] ? DPRO_CMD_ACT : DPRO_CMD_PRE;
      end
      @(posedge ref_clk_i);
      cmd_o <= DPRO_CMD_NOP;
      @(posedge ref_clk_i);
      cke_o <= 1'b1;
      repeat (TXPDLL_CYC) @(posedge ref_clk_i);
   endtask
   task automatic rst_assert();
      @(posedge ref_clk_i);
      reset_n_o <= 1'b0;
      cke_o <= 1'b0;
      repeat (RST_LOW_CYC) @(posedge ref_clk_i);
   endtask
   task automatic rst_release();
      reset_n_o <= 1'b1;
      repeat (TXPDLL_CYC) @(posedge ref_clk_i);
      cke_o <= 1'b1;
      repeat (TXPDLL_CYC) @(posedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

// file: verification/test_dpro_ctl.sv
// Self-checking bench for the power, reset and termination control block
`default_nettype none
module test_dpro_ctl import dpro_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o, rdat;
   logic avs_waitrequest_o, cke_i, reset_n_i, odt_i;
   logic [1:0] avs_response_o, rrsp;
   logic [2:0] cmd_i, pstate_o;
   logic [DPRO_DQ_W-1:0] rtt_en_o;
   logic rtt_tdqs_o, rtt_dyn_o, odt_async_o, out_en_o, buf_en_o, dll_on_o;
   int err_count = 0;
   int n_checks = 0;
   localparam logic [2:0] PD_ST [3] = '{3'h2, 3'h3, 3'h1};
   always #2.5 ref_clk_i = ~ref_clk_i;
   dpro_ctl dpro_ctl_i (.ref_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .avs_response_o, .cke_i, .reset_n_i, .odt_i, .cmd_i, .rtt_en_o, .rtt_tdqs_o,
      .rtt_dyn_o, .odt_async_o, .out_en_o, .buf_en_o, .dll_on_o, .pstate_o);
   dpro_mc_model dpro_mc_model_i (.ref_clk_i, .cke_o(cke_i), .reset_n_o(reset_n_i),
      .odt_o(odt_i), .cmd_o(cmd_i));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One idle cycle before each request keeps release and the next request apart
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge ref_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      rdat = avs_readdata_o;
      rrsp = avs_response_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      chk("bus answer", 32'(i < 20), 32'h1);
      if (i == 20) summarize();
   endtask
   task automatic wait_st(input logic [2:0] s);
      int i;
      for (i = 0; i < 80 && pstate_o !== s; i++) @(posedge ref_clk_i);
      chk("pstate", 32'(pstate_o), 32'(s));
      if (pstate_o !== s) summarize();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      wait_st(3'h0);
      for (int a = 4; a <= 12; a += 4) begin
         bus(1'b0, a[7:0], 32'h0);
         chk("mode reset", rdat, 32'h0);
      end
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped rsp", 32'(rrsp), 32'h2);
      chk("unmapped data", rdat, 32'h0);
      bus(1'b1, DPRO_OFS_STAT, 32'hFFFF_FFFF);
      bus(1'b0, DPRO_OFS_STAT, 32'h0);
      chk("status state", 32'(rdat[2:0]), 32'h0);
      bus(1'b1, DPRO_OFS_MR0, 32'hFFFF_1000);
      bus(1'b0, DPRO_OFS_MR0, 32'h0);
      chk("mr0 upper", rdat, 32'h0000_1000);
      avs_byteenable_i <= 4'h2;
      bus(1'b1, DPRO_OFS_MR0, 32'h0000_0EFF);
      avs_byteenable_i <= 4'hF;
      bus(1'b0, DPRO_OFS_MR0, 32'h0);
      chk("mr0 byte merge", rdat, 32'h0000_0E00);
      // Fast precharge, slow precharge, then active with the fast bit still clear
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, DPRO_OFS_MR0, k == 0 ? 32'h1000 : 32'h0);
         dpro_mc_model_i.cmd(k == 2 ? DPRO_CMD_ACT : DPRO_CMD_PRE);
         dpro_mc_model_i.pd_enter();
         wait_st(PD_ST[k]);
         dpro_mc_model_i.cyc(2);
         chk("dll in pd", 32'(dll_on_o), 32'(k != 1));
         chk("buffers in pd", 32'(buf_en_o), 32'h0);
         if (k == 1) chk("odt async", 32'(odt_async_o), 32'h1);
         if (k < 2) begin
            dpro_mc_model_i.pd_exit();
            wait_st(3'h0);
            dpro_mc_model_i.cyc(4);
            chk("dll after exit", 32'(dll_on_o), 32'h1);
            chk("buffers after exit", 32'(buf_en_o), 32'h1);
            if (k == 1) begin
               dpro_mc_model_i.cmd(DPRO_CMD_REF);
               dpro_mc_model_i.cyc(2);
               bus(1'b0, DPRO_OFS_CNT, 32'h0);
               chk("refresh count", rdat, 32'h1);
            end
         end
      end
      bus(1'b1, DPRO_OFS_MR1, 32'h0004);
      dpro_mc_model_i.set_odt(1'b1);
      dpro_mc_model_i.rst_assert();
      chk("reset state", 32'(pstate_o), 32'h4);
      chk("out en", 32'(out_en_o), 32'h0);
      chk("rtt in reset", 32'(rtt_en_o), 32'h0);
      dpro_mc_model_i.rst_release();
      wait_st(3'h0);
      bus(1'b0, DPRO_OFS_MR1, 32'h0);
      chk("mr1 cleared", rdat, 32'h0);
      bus(1'b0, DPRO_OFS_CNT, 32'h0);
      chk("refresh cleared", rdat, 32'h0);
      bus(1'b1, DPRO_OFS_MR1, 32'h0804);
      dpro_mc_model_i.cyc(6);
      chk("rtt nom", 32'(rtt_en_o), 32'hFF);
      chk("rtt tdqs", 32'(rtt_tdqs_o), 32'h1);
      avs_byteenable_i <= 4'h2;
      bus(1'b1, DPRO_OFS_MR2, 32'h0000_02FF);
      avs_byteenable_i <= 4'hF;
      bus(1'b0, DPRO_OFS_MR2, 32'h0);
      chk("mr2 byte merge", rdat, 32'h0000_0200);
      dpro_mc_model_i.cmd(DPRO_CMD_WR);
      dpro_mc_model_i.cyc(4);
      chk("rtt dyn in write", 32'(rtt_dyn_o), 32'h1);
      dpro_mc_model_i.cyc(1);
      chk("rtt dyn after write", 32'(rtt_dyn_o), 32'h0);
      bus(1'b1, DPRO_OFS_MR2, 32'h0);
      bus(1'b1, DPRO_OFS_MR1, 32'h0805);
      dpro_mc_model_i.cyc(6);
      chk("rtt dll off", 32'(rtt_en_o), 32'h0);
      bus(1'b1, DPRO_OFS_MR1, 32'h0);
      dpro_mc_model_i.cyc(6);
      chk("rtt mode off", 32'(rtt_en_o), 32'h0);
      dpro_mc_model_i.set_odt(1'b0);
      dpro_mc_model_i.cyc(8);
      summarize();
   end
endmodule
bind dpro_ctl dpro_ctl_asserts dpro_ctl_asserts_i (.ref_clk_i, .sys_rst_i, .avs_address_i,
   .avs_read_i, .avs_write_i, .avs_waitrequest_o, .avs_response_o, .cke_i, .reset_n_i,
   .odt_i, .rtt_en_o, .rtt_tdqs_o, .out_en_o, .dll_on_o, .pstate_o);
`default_nettype wire
